// ===== ace_evaluator.sv
// Analog channel evaluator: scaling, limits, redundancy, division and comparators.
// Assumes an AHB-Lite master, sensor readings in uA or mV synchronous to clock.
//
// Functional notes
// - Two enabled threshold comparators each with own threshold; flags only when enabled.
// - Under state stays while value at or below threshold, goes over above it.
// - Over state returns under only below threshold minus hysteresis.
// - Comparator output is one when over, zero when under.
// - Sample rate chosen from a list; 50 and 60 per second included.
// - Minimum current limit configurable between 2.5 mA and 3.9 mA.
// - Maximum current limit configurable between 20.1 mA and 23 mA.
// - Current diagnostic below minimum or above maximum, none strictly between.
// - Voltage maximum limit 10.05 V to 11.5 V; diagnostic above it.
// - No voltage diagnostic at or below the maximum limit.
// - Sensor anomaly replaces measurement with 0 mA or 25 mA.
// - Anomalies: open cable (4-20 mA only), supply overload, input overload.
// - Enabled error output is one while an anomaly is present.
// - Raw values readable only when the raw-value option is on.
// - Division of this input's value by another input's value.
// - One threshold comparator applied to the division result.
// - Division anomaly forces result to 0 or 200000.
// - Incoherence when deviation exceeds limit longer than timeout.
// - Different sensors: second reading rescaled to first scale.
// - Consolidation selects primary, redundant or maximum.
// - Consolidation also offers minimum and arithmetic mean.
// - Linear scaling; zero point 4 mA, 0 mA or 0 V by range.
`timescale 1ns/1ps
`include "ace_map.svh"
module ace_evaluator
  import ace_pkg::*;
#(
  parameter int BASE_CYCLES = `ACE_BASE_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Sensor side.
  input  wire logic [15:0] primaryChannelValue,
  input  wire logic [15:0] redundantChannelValue,
  input  wire logic        cableOpen,
  input  wire logic        supplyOverload,
  input  wire logic        inputOverload,
  input  wire logic [31:0] divisorValue,
  // Controller side.
  output logic             sampleStrobe,
  output logic             firstLevelFlag,
  output logic             secondLevelFlag,
  output logic             divisionFlag,
  output logic             errorOut,
  output logic             limitDiag,
  output logic             incoherent,
  output logic [31:0]      consolidatedValue,
  output logic [31:0]      divisionResult
);
  // --------------------------------------------------------------------------
  // Register file and bus
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_reg, ctrl_next, cfg_reg [14], cfg_next [14];
  logic [15:0] rawP_reg, rawP_next, rawR_reg, rawR_next;
  logic [7:0]  wrAddr_reg, wrAddr_next;
  logic        wrPend_reg, wrPend_next, cfgTouch_reg, cfgTouch_next;
  logic [31:0] rdata_reg, rdata_next, status;
  logic        addrPhase, ctrlWrite, ready_reg;
  logic [15:0] wlo;
  ace_range_type range;

  assign addrPhase = hsel && hready && htrans[1];
  assign ctrlWrite = wrPend_reg && (wrAddr_reg == `ACE_OFF_CTRL);
  assign range     = ace_range_type'(ctrl_reg[`ACE_CTL_RANGE]);
  assign wlo       = hwdata[15:0];

  // Writes land in the data phase; limit registers clamp into their legal span.
  always_comb begin
    ctrl_next     = ctrl_reg;
    cfg_next      = cfg_reg;
    wrPend_next   = addrPhase && hwrite;
    wrAddr_next   = addrPhase ? haddr[7:0] : wrAddr_reg;
    cfgTouch_next = ctrlWrite;
    rdata_next    = 32'h0000_0000;
    if (wrPend_reg) begin
      case (wrAddr_reg)
        `ACE_OFF_CTRL:    ctrl_next = hwdata;
        `ACE_OFF_MINCUR:  cfg_next[12] = {16'h0000, wlo < `ACE_MINCUR_LO ? `ACE_MINCUR_LO :
                            (wlo > `ACE_MINCUR_HI ? `ACE_MINCUR_HI : wlo)};
        `ACE_OFF_MAXCUR:  cfg_next[13] = {16'h0000, wlo < `ACE_MAXCUR_LO ? `ACE_MAXCUR_LO :
                            (wlo > `ACE_MAXCUR_HI ? `ACE_MAXCUR_HI : wlo)};
        `ACE_OFF_MAXVOLT: cfg_next[0] = {16'h0000, wlo < `ACE_MAXV_LO ? `ACE_MAXV_LO :
                            (wlo > `ACE_MAXV_HI ? `ACE_MAXV_HI : wlo)};
        default: begin
          if (wrAddr_reg[7:2] >= 6'h01 && wrAddr_reg[7:2] <= 6'h0B)
            cfg_next[wrAddr_reg[5:2]] = hwdata;
        end
      endcase
    end
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        `ACE_OFF_CTRL:    rdata_next = ctrl_reg;
        `ACE_OFF_MAXVOLT: rdata_next = cfg_reg[0];
        `ACE_OFF_STATUS:  rdata_next = status;
        `ACE_OFF_CONSOL:  rdata_next = consolidatedValue;
        `ACE_OFF_DIVRES:  rdata_next = divisionResult;
        `ACE_OFF_RAWP:    rdata_next = ctrl_reg[`ACE_CTL_RAWEN] ? {16'h0000, rawP_reg} :
                                       32'h0000_0000;
        `ACE_OFF_RAWR:    rdata_next = ctrl_reg[`ACE_CTL_RAWEN] ? {16'h0000, rawR_reg} :
                                       32'h0000_0000;
        default: begin
          if (haddr[7:2] >= 6'h01 && haddr[7:2] <= 6'h0D && haddr[1:0] == 2'h0)
            rdata_next = cfg_reg[haddr[5:2]];
        end
      endcase
    end
  end

  // Reset values: unit gains, limits at the narrowest legal span.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg     <= `ACE_CTL_RESET;
      for (int i = 0; i < 14; i++) cfg_reg[i] <= 32'h0000_0000;
      cfg_reg[6]   <= `ACE_GAIN_RESET;
      cfg_reg[8]   <= `ACE_GAIN_RESET;
      cfg_reg[12]  <= {16'h0000, `ACE_MINCUR_HI};
      cfg_reg[13]  <= {16'h0000, `ACE_MAXCUR_LO};
      cfg_reg[0]   <= {16'h0000, `ACE_MAXV_LO};
      wrPend_reg   <= 1'b0;
      wrAddr_reg   <= 8'h00;
      cfgTouch_reg <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      ready_reg    <= 1'b0;
    end else begin
      ready_reg    <= 1'b1;
      ctrl_reg     <= ctrl_next;
      cfg_reg      <= cfg_next;
      wrPend_reg   <= wrPend_next;
      wrAddr_reg   <= wrAddr_next;
      cfgTouch_reg <= cfgTouch_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Zero-wait slave: ready is a flip-flop, low in reset and high from the first edge after.
  assign hrdata    = rdata_reg;
  assign hreadyout = ready_reg;
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------------
  // Sample pacing
  // --------------------------------------------------------------------------
  logic [15:0] baseCnt_reg, baseCnt_next;
  logic [11:0] perCnt_reg, perCnt_next, period;
  logic        strobe_reg, strobe_next, baseTick;

  // Two-stage pacing keeps every counter well under the long-count ceiling.
  always_comb begin
    case (ctrl_reg[`ACE_CTL_RATE])
      3'h0:    period = `ACE_PER_10;
      3'h1:    period = `ACE_PER_25;
      3'h2:    period = `ACE_PER_50;
      3'h3:    period = `ACE_PER_60;
      3'h4:    period = `ACE_PER_100;
      default: period = `ACE_PER_200;
    endcase
    baseTick     = (baseCnt_reg == 16'(BASE_CYCLES - 1));
    baseCnt_next = baseTick ? 16'h0000 : baseCnt_reg + 16'h0001;
    perCnt_next  = perCnt_reg;
    strobe_next  = 1'b0;
    rawP_next    = rawP_reg;
    rawR_next    = rawR_reg;
    if (baseTick) begin
      if (perCnt_reg + 12'h001 >= period) begin
        perCnt_next = 12'h000;
        strobe_next = 1'b1;
        rawP_next   = primaryChannelValue;
        rawR_next   = redundantChannelValue;
      end else begin
        perCnt_next = perCnt_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      baseCnt_reg <= 16'h0000;
      perCnt_reg  <= 12'h000;
      strobe_reg  <= 1'b0;
      rawP_reg    <= 16'h0000;
      rawR_reg    <= 16'h0000;
    end else begin
      baseCnt_reg <= baseCnt_next;
      perCnt_reg  <= perCnt_next;
      strobe_reg  <= strobe_next;
      rawP_reg    <= rawP_next;
      rawR_reg    <= rawR_next;
    end
  end
  assign sampleStrobe = strobe_reg;

  // --------------------------------------------------------------------------
  // Scaling, limits, anomaly and consolidation
  // --------------------------------------------------------------------------
  logic        anomaly, diag, devOver;
  logic [15:0] measP, measR, zero, satRaw;
  logic signed [31:0] engP, engR, cons, diffPR;
  logic signed [32:0] sum;
  logic signed [48:0] prodP, prodR;

  always_comb begin
    anomaly = (cableOpen && range == ACE_RANGE_4_20) || supplyOverload || inputOverload;
    satRaw  = ctrl_reg[`ACE_CTL_SATHI] ? `ACE_SAT_25MA : 16'h0000;
    measP   = anomaly ? satRaw : rawP_reg;
    measR   = anomaly ? satRaw : rawR_reg;
    zero    = (range == ACE_RANGE_4_20) ? `ACE_ZERO_4MA : 16'h0000;
    prodP   = 49'(signed'({1'b0, measP}) - signed'({1'b0, zero})) * signed'(cfg_reg[6]);
    prodR   = 49'(signed'({1'b0, measR}) - signed'({1'b0, zero})) *
              signed'(ctrl_reg[`ACE_CTL_DIFF] ? cfg_reg[8] : cfg_reg[6]);
    engP    = signed'(cfg_reg[7]) + signed'(prodP[47:16]);
    engR    = signed'(ctrl_reg[`ACE_CTL_DIFF] ? cfg_reg[9] : cfg_reg[7]) +
              signed'(prodR[47:16]);
    diffPR  = engP - engR;
    devOver = ctrl_reg[`ACE_CTL_RED] &&
              ((diffPR < 0 ? -diffPR : diffPR) > signed'(cfg_reg[10]));
    sum     = 33'(engP) + 33'(engR);
    if (!ctrl_reg[`ACE_CTL_RED]) cons = engP;
    else begin
      case (ace_cons_type'(ctrl_reg[`ACE_CTL_CONS]))
        ACE_CONS_PRI: cons = engP;
        ACE_CONS_RED: cons = engR;
        ACE_CONS_MAX: cons = (engP > engR) ? engP : engR;
        ACE_CONS_MIN: cons = (engP < engR) ? engP : engR;
        ACE_CONS_AVG: cons = sum[32:1];
        default:      cons = engP;
      endcase
    end
    if (range == ACE_RANGE_0_10V)
      diag = rawP_reg > cfg_reg[0][15:0];
    else
      diag = (rawP_reg < cfg_reg[12][15:0]) || (rawP_reg > cfg_reg[13][15:0]);
  end

  // --------------------------------------------------------------------------
  // Coherence timer, result registers
  // --------------------------------------------------------------------------
  logic [31:0] cohCnt_reg, cohCnt_next, cons_reg;
  logic        incoh_reg, incoh_next, err_reg, diag_reg;

  // The timer runs in base ticks so the timeout is compared in whole ms.
  always_comb begin
    cohCnt_next = devOver ? (baseTick ? cohCnt_reg + 32'h0000_0001 : cohCnt_reg)
                          : 32'h0000_0000;
    incoh_next  = devOver && (cohCnt_reg > cfg_reg[11] * `ACE_TICKS_PER_MS);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cohCnt_reg <= 32'h0000_0000;
      incoh_reg  <= 1'b0;
      err_reg    <= 1'b0;
      diag_reg   <= 1'b0;
      cons_reg   <= 32'h0000_0000;
    end else begin
      cohCnt_reg <= cohCnt_next;
      incoh_reg  <= incoh_next;
      err_reg    <= ctrl_reg[`ACE_CTL_ERREN] && anomaly;
      diag_reg   <= diag;
      cons_reg   <= cons;
    end
  end
  assign errorOut          = err_reg;
  assign limitDiag         = diag_reg;
  assign incoherent        = incoh_reg;
  assign consolidatedValue = cons_reg;
  assign status = {25'h000_0000, divisionFlag, secondLevelFlag, firstLevelFlag,
                   incoh_reg, diag_reg, err_reg, anomaly};

  // --------------------------------------------------------------------------
  // Division: restoring divider started by each sample
  // --------------------------------------------------------------------------
  ace_div_state_type dState_reg, dState_next;
  logic [31:0] quo_reg, quo_next, den_reg, den_next, divRes_reg, divRes_next;
  logic [32:0] rem_reg, rem_next, trial;
  logic [5:0]  step_reg, step_next;
  logic        neg_reg, neg_next;

  // Iterative division trades 32 cycles of latency for one adder.
  always_comb begin
    dState_next = dState_reg;
    quo_next    = quo_reg;
    den_next    = den_reg;
    rem_next    = rem_reg;
    step_next   = step_reg;
    neg_next    = neg_reg;
    divRes_next = divRes_reg;
    trial       = {rem_reg[31:0], quo_reg[31]} - {1'b0, den_reg};
    case (dState_reg)
      ACE_DIV_IDLE: begin
        if (strobe_reg) begin
          if (divisorValue == 32'h0000_0000)
            divRes_next = ctrl_reg[`ACE_CTL_DSATHI] ? `ACE_DIV_SAT_HI : 32'h0000_0000;
          else begin
            quo_next    = cons[31] ? 32'(-cons) : cons;
            den_next    = divisorValue[31] ? 32'(-signed'(divisorValue)) : divisorValue;
            neg_next    = cons[31] ^ divisorValue[31];
            rem_next    = 33'h0_0000_0000;
            step_next   = 6'h00;
            dState_next = ACE_DIV_RUN;
          end
        end
      end
      ACE_DIV_RUN: begin
        if (!trial[32]) begin
          rem_next = trial;
          quo_next = {quo_reg[30:0], 1'b1};
        end else begin
          rem_next = {rem_reg[31:0], quo_reg[31]};
          quo_next = {quo_reg[30:0], 1'b0};
        end
        step_next = step_reg + 6'h01;
        if (step_reg == `ACE_DIV_STEPS - 6'h01) begin
          divRes_next = neg_reg ? 32'(-signed'(quo_next)) : quo_next;
          dState_next = ACE_DIV_IDLE;
        end
      end
      default: dState_next = ACE_DIV_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dState_reg <= ACE_DIV_IDLE;
      quo_reg    <= 32'h0000_0000;
      den_reg    <= 32'h0000_0000;
      rem_reg    <= 33'h0_0000_0000;
      step_reg   <= 6'h00;
      neg_reg    <= 1'b0;
      divRes_reg <= 32'h0000_0000;
    end else begin
      dState_reg <= dState_next;
      quo_reg    <= quo_next;
      den_reg    <= den_next;
      rem_reg    <= rem_next;
      step_reg   <= step_next;
      neg_reg    <= neg_next;
      divRes_reg <= divRes_next;
    end
  end
  assign divisionResult = divRes_reg;

  // --------------------------------------------------------------------------
  // Threshold comparators with hysteresis
  // --------------------------------------------------------------------------
  logic [2:0] over_reg, over_next, cmpEn;
  logic signed [31:0] cmpVal [3], cmpThr [3], cmpHys [3];
  assign cmpEn     = ctrl_reg[`ACE_CTL_CMPEN];
  assign cmpVal[0] = cons_reg;
  assign cmpVal[1] = cons_reg;
  assign cmpVal[2] = divRes_reg;
  assign cmpThr[0] = cfg_reg[1];
  assign cmpThr[1] = cfg_reg[2];
  assign cmpThr[2] = cfg_reg[4];
  assign cmpHys[0] = cfg_reg[3];
  assign cmpHys[1] = cfg_reg[3];
  assign cmpHys[2] = cfg_reg[5];

  // A disabled comparator is parked under threshold so it restarts cleanly.
  for (genvar i = 0; i < 3; i++) begin : g_cmp
    always_comb begin
      if (!cmpEn[i] || cfgTouch_reg)
        over_next[i] = 1'b0;
      else if (over_reg[i])
        over_next[i] = !(cmpVal[i] < cmpThr[i] - cmpHys[i]);
      else
        over_next[i] = cmpVal[i] > cmpThr[i];
    end
    always_ff @(posedge clock or posedge reset) begin
      if (reset) over_reg[i] <= 1'b0;
      else       over_reg[i] <= over_next[i];
    end
  end
  assign firstLevelFlag  = over_reg[0];
  assign secondLevelFlag = over_reg[1];
  assign divisionFlag    = over_reg[2];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_flag_rise: assert property (cmpEn[0] && !cfgTouch_reg && !over_reg[0] &&
    signed'(cons_reg) > signed'(cfg_reg[1]) |=> firstLevelFlag)
    else $error("comparator did not rise above threshold");
  a_flag_hold: assert property (cmpEn[0] && !cfgTouch_reg && over_reg[0] &&
    !(signed'(cons_reg) < signed'(cfg_reg[1]) - signed'(cfg_reg[3])) |=>
    firstLevelFlag)
    else $error("comparator fell inside hysteresis band");
  a_flag_off: assert property (!cmpEn[1] |=> !secondLevelFlag)
    else $error("disabled comparator drove its flag");
  a_reconfig_clear: assert property (ctrlWrite |=> ##1 over_reg == 3'h0)
    else $error("comparators not cleared on reconfiguration");
  a_error_out: assert property (##1 errorOut ==
    $past(ctrl_reg[`ACE_CTL_ERREN] && anomaly))
    else $error("error output does not follow anomaly");
  a_volt_diag: assert property (range == ACE_RANGE_0_10V &&
    rawP_reg <= cfg_reg[0][15:0] |=> !limitDiag)
    else $error("voltage diagnostic raised inside limit");
  a_cur_diag: assert property (range == ACE_RANGE_4_20 &&
    rawP_reg < cfg_reg[12][15:0] |=> limitDiag)
    else $error("missing undercurrent diagnostic");
  a_div_sat: assert property (dState_reg == ACE_DIV_IDLE && strobe_reg &&
    divisorValue == 32'h0000_0000 && ctrl_reg[`ACE_CTL_DSATHI] |=>
    divisionResult == `ACE_DIV_SAT_HI)
    else $error("division by zero not saturated");
  a_div_done: assert property (dState_reg == ACE_DIV_RUN |-> ##[1:32] dState_reg == ACE_DIV_IDLE)
    else $error("divider did not finish in 32 cycles");
  a_limit_clamp: assert property (cfg_reg[12][15:0] >= `ACE_MINCUR_LO &&
    cfg_reg[12][15:0] <= `ACE_MINCUR_HI)
    else $error("minimum current limit out of span");

  c_flag_cycle: cover property (firstLevelFlag ##[1:1000] !firstLevelFlag);
  c_div_run: cover property (dState_reg == ACE_DIV_RUN ##[1:40] dState_reg == ACE_DIV_IDLE);
  c_incoherent: cover property (incoherent);
  c_anomaly_err: cover property (errorOut && limitDiag);
endmodule : ace_evaluator

// ===== ace_map.svh
// Register map, field positions, limits and timing counts of the analog evaluator.
// Assumes a 20 MHz module clock; included by the top module and the bench.
`ifndef ACE_MAP_SVH
`define ACE_MAP_SVH
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ACE_CLK_NS        50
`define ACE_BASE_NS       50000
`define ACE_BASE_CYCLES   (`ACE_BASE_NS / `ACE_CLK_NS)
`define ACE_TICKS_PER_MS  32'h0000_0014
`define ACE_DIV_STEPS     6'h20
// Sample periods in 50 us base ticks for 10, 25, 50, 60, 100 and 200 samples/s.
`define ACE_PER_10        12'h07D0
`define ACE_PER_25        12'h0320
`define ACE_PER_50        12'h0190
`define ACE_PER_60        12'h014D
`define ACE_PER_100       12'h00C8
`define ACE_PER_200       12'h0064
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ACE_OFF_CTRL      8'h00
`define ACE_OFF_THR1      8'h04
`define ACE_OFF_THR2      8'h08
`define ACE_OFF_HYST      8'h0C
`define ACE_OFF_DTHR      8'h10
`define ACE_OFF_DHYST     8'h14
`define ACE_OFF_GAINP     8'h18
`define ACE_OFF_OFFSP     8'h1C
`define ACE_OFF_GAINR     8'h20
`define ACE_OFF_OFFSR     8'h24
`define ACE_OFF_MAXDEV    8'h28
`define ACE_OFF_TMO       8'h2C
`define ACE_OFF_MINCUR    8'h30
`define ACE_OFF_MAXCUR    8'h34
`define ACE_OFF_MAXVOLT   8'h38
`define ACE_OFF_STATUS    8'h3C
`define ACE_OFF_CONSOL    8'h40
`define ACE_OFF_DIVRES    8'h44
`define ACE_OFF_RAWP      8'h48
`define ACE_OFF_RAWR      8'h4C
// ----------------------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------------------
`define ACE_CTL_RED       0
`define ACE_CTL_DIFF      1
`define ACE_CTL_CONS      4:2
`define ACE_CTL_RANGE     6:5
`define ACE_CTL_RATE      9:7
`define ACE_CTL_SATHI     10
`define ACE_CTL_DSATHI    11
`define ACE_CTL_ERREN     12
`define ACE_CTL_RAWEN     13
`define ACE_CTL_CMPEN     16:14
`define ACE_CTL_RESET     32'h0000_0000
// ----------------------------------------------------------------------------
// Physical values (uA or mV) and saturation values
// ----------------------------------------------------------------------------
`define ACE_MINCUR_LO     16'h09C4
`define ACE_MINCUR_HI     16'h0F3C
`define ACE_MAXCUR_LO     16'h4E84
`define ACE_MAXCUR_HI     16'h59D8
`define ACE_MAXV_LO       16'h2742
`define ACE_MAXV_HI       16'h2CEC
`define ACE_ZERO_4MA      16'h0FA0
`define ACE_SAT_25MA      16'h61A8
`define ACE_DIV_SAT_HI    32'h0003_0D40
`define ACE_GAIN_RESET    32'h0001_0000
`endif

// ===== ace_pkg.sv
// Types shared by the analog evaluator.
// Assumes the register map header sits in the same folder.
package ace_pkg;
  typedef enum logic [1:0] {ACE_RANGE_4_20 = 2'h0, ACE_RANGE_0_20 = 2'h1,
                            ACE_RANGE_0_10V = 2'h2} ace_range_type;
  typedef enum logic [2:0] {ACE_CONS_PRI = 3'h0, ACE_CONS_RED = 3'h1, ACE_CONS_MAX = 3'h2,
                            ACE_CONS_MIN = 3'h3, ACE_CONS_AVG = 3'h4} ace_cons_type;
  typedef enum logic [1:0] {ACE_DIV_IDLE = 2'h1, ACE_DIV_RUN = 2'h2} ace_div_state_type;
endpackage : ace_pkg

// ===== ace_sensor_model.sv
// Sensor pair model: drives readings and cable state asked by the bench.
// Assumes one clock; values move just after a rising edge.
`timescale 1ns/1ps
module ace_sensor_model (
  // Clock.
  input  wire logic        clock,
  // Targets from the bench.
  input  wire logic [15:0] setP,
  input  wire logic [15:0] setR,
  input  wire logic        setOpen,
  // Sensor lines.
  output logic      [15:0] primaryChannelValue,
  output logic      [15:0] redundantChannelValue,
  output logic             cableOpen
);
  // Registered so a new reading never races the capture edge.
  always_ff @(posedge clock) begin
    primaryChannelValue   <= setP;
    redundantChannelValue <= setR;
    cableOpen             <= setOpen;
  end
endmodule : ace_sensor_model

// ===== analog_channel_evaluator_test.sv
// Self-checking bench of the analog evaluator over AHB-Lite.
// Assumes the sensor model is compiled before this file.
`timescale 1ns/1ps
`include "ace_map.svh"
module analog_channel_evaluator_test;
  import ace_pkg::*;
  logic clock = 0, reset = 1, hsel = 0, hwrite = 0, hready, setOpen = 0, supOv = 0, inOv = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, cons, divR, divV = 32'h0000_0002;
  logic [15:0] setP = 0, setR = 0, pv, rv;
  logic hreadyout, hresp, strobe, flag1, flag2, dflag, errorOut, diag, incoh, cab;
  int n_fail = 0, num_checks = 0;
  assign hready = hreadyout;
  // Short base tick keeps a 200 sample/s period at 400 clocks.
  ace_evaluator #(.BASE_CYCLES(4)) DUT (.clock(clock), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .primaryChannelValue(pv), .redundantChannelValue(rv), .cableOpen(cab),
    .supplyOverload(supOv), .inputOverload(inOv), .divisorValue(divV),
    .sampleStrobe(strobe), .firstLevelFlag(flag1), .secondLevelFlag(flag2),
    .divisionFlag(dflag), .errorOut(errorOut), .limitDiag(diag), .incoherent(incoh),
    .consolidatedValue(cons), .divisionResult(divR));
  ace_sensor_model SENS (.clock(clock), .setP(setP), .setR(setR), .setOpen(setOpen),
    .primaryChannelValue(pv), .redundantChannelValue(rv), .cableOpen(cab));
  // Clock at 50 ns.
  always #25 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One single transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Two strobes so a new reading is surely captured, then let flags settle.
  task automatic sample();
    repeat (2) do @(posedge clock); while (strobe !== 1'b1);
    repeat (3) @(posedge clock);
  endtask : sample
  task automatic t_regs();
    bus(0, `ACE_OFF_CTRL, 0);
    chk(rd, `ACE_CTL_RESET);
    chk(hresp, 1'b0);
    bus(1, `ACE_OFF_MINCUR, 32'h0000_03E8);
    bus(0, `ACE_OFF_MINCUR, 0);
    chk(rd, 32'h0000_09C4);
    bus(1, `ACE_OFF_MAXCUR, 32'h0000_7530);
    bus(0, `ACE_OFF_MAXCUR, 0);
    chk(rd, 32'h0000_59D8);
    bus(0, 32'h0000_0080, 0);
    chk(rd, 32'h0000_0000);
  endtask : t_regs
  task automatic t_cons();
    logic [31:0] e[5] = '{32'h1388, 32'h1B58, 32'h1B58, 32'h1388, 32'h1770};
    setP <= 16'h1388;
    setR <= 16'h1B58;
    for (int c = 0; c < 5; c++) begin
      bus(1, `ACE_OFF_CTRL, 32'h0000_02A1 | (c << 2));
      sample();
      chk(cons, e[c]);
    end
    chk(incoh, 1'b1);
    bus(1, `ACE_OFF_MAXDEV, 32'h0000_0BB8);
    sample();
    chk(incoh, 1'b0);
    bus(1, `ACE_OFF_GAINR, 32'h0002_0000);
    bus(1, `ACE_OFF_CTRL, 32'h0000_02A7);
    sample();
    chk(cons, 32'h0000_36B0);
    chk(incoh, 1'b1);
  endtask : t_cons
  task automatic t_cmp();
    logic [15:0] v[4] = '{16'h1770, 16'h1771, 16'h157C, 16'h1387};
    logic f[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    bus(1, `ACE_OFF_THR1, 32'h0000_1770);
    bus(1, `ACE_OFF_HYST, 32'h0000_03E8);
    bus(1, `ACE_OFF_CTRL, 32'h0000_42A0);
    for (int i = 0; i < 4; i++) begin
      setP <= v[i];
      sample();
      chk(flag1, f[i]);
      chk(flag2, 1'b0);
    end
  endtask : t_cmp
  task automatic t_diag();
    logic [31:0] k[5] = '{32'h280, 32'h280, 32'h280, 32'h2C0, 32'h2C0};
    logic [15:0] v[5] = '{16'h0960, 16'h2710, 16'h5DC0, 16'h2AF8, 16'h0064};
    logic d[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      bus(1, `ACE_OFF_CTRL, k[i]);
      setP <= v[i];
      sample();
      chk(diag, d[i]);
    end
  endtask : t_diag
  task automatic t_anom();
    bus(1, `ACE_OFF_CTRL, 32'h0000_16A0);
    supOv <= 1'b1;
    sample();
    chk(errorOut, 1'b1);
    chk(cons, 32'h0000_61A8);
    supOv <= 1'b0;
    bus(1, `ACE_OFF_CTRL, 32'h0000_1680);
    setOpen <= 1'b1;
    sample();
    chk(errorOut, 1'b1);
    chk(cons, 32'h0000_5208);
    setOpen <= 1'b0;
    inOv    <= 1'b1;
    sample();
    chk(errorOut, 1'b1);
    inOv <= 1'b0;
    sample();
    chk(errorOut, 1'b0);
  endtask : t_anom
  // Division of 5000 by 2, then by zero with the high saturation chosen.
  task automatic t_div();
    bus(1, `ACE_OFF_DTHR, 32'h0000_03E8);
    bus(1, `ACE_OFF_CTRL, 32'h0001_2AA0);
    setP <= 16'h1388;
    sample();
    repeat (40) @(posedge clock);
    chk(divR, 32'h0000_09C4);
    chk(dflag, 1'b1);
    bus(0, `ACE_OFF_RAWP, 0);
    chk(rd, 32'h0000_1388);
    divV <= 32'h0000_0000;
    sample();
    chk(divR, 32'h0003_0D40);
  endtask : t_div
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Watchdog: about 40000 clocks, well above the expected run.
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_cons();
    t_cmp();
    t_diag();
    t_anom();
    t_div();
    tally_and_finish();
  end
endmodule : analog_channel_evaluator_test
